/* File: logic/adcc_conv_if.sv */
// adcc_conv_if: signals shared by the register core, the prescaler and the conversion sequencer.
// assumes all three parties run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface adcc_conv_if;
  logic                        run;     // converter powered, prescaler counting
  logic [adcc_pkg::DIV_W-1:0]  div_sel; // prescaler code
  logic                        tick;    // one-cycle converter clock enable
  logic                        start;   // begin a conversion
  logic                        first;   // the conversion to begin is the long one
  logic                        abort;   // end the running conversion without result
  logic                        done;    // one-cycle completion pulse
  logic                        busy;    // a conversion is running
  modport ctrl    (output run, output div_sel, output start, output first, output abort,
                   input done, input busy);
  modport divider (input run, input div_sel, output tick);
  modport seq     (input tick, input start, input first, input abort, output done, output busy);
endinterface : adcc_conv_if
`default_nettype wire

/* File: logic/adcc_conv_seq.sv */
// adcc_conv_seq: times one conversion in converter clock cycles and reports its end.
// assumes start only arrives while idle; a start while busy is dropped.
`timescale 1ns/1ps
`default_nettype none
module adcc_conv_seq (
  input  wire logic clk_i,
  input  wire logic rst_i,
  adcc_conv_if.seq  conv
);
  typedef struct packed {
    adcc_pkg::adcc_conv_state_t st;
    logic [adcc_pkg::CNT_W-1:0] cnt;
    logic [adcc_pkg::CNT_W-1:0] last;
    logic                       done;
  } adcc_seq_state_t;

  adcc_seq_state_t s;
  adcc_seq_state_t next_s;

  // the long first conversion covers the converter's own initialisation
  always_comb
  begin
    next_s      = s;
    next_s.done = 1'b0;
    case (s.st)
      adcc_pkg::CONV_IDLE:
      begin
        if (conv.start)
        begin
          next_s.st   = adcc_pkg::CONV_RUN;
          next_s.cnt  = '0;
          next_s.last = conv.first ? 5'(adcc_pkg::FIRST_CONV_CYCLES - 1)
                                   : 5'(adcc_pkg::NORMAL_CONV_CYCLES - 1);
        end
      end
      adcc_pkg::CONV_RUN:
      begin
        if (conv.abort)
          next_s.st = adcc_pkg::CONV_IDLE;
        else if (conv.tick)
        begin
          if (s.cnt == s.last)
          begin
            next_s.st   = adcc_pkg::CONV_IDLE;
            next_s.done = 1'b1;
          end
          else
            next_s.cnt = s.cnt + 5'h01;
        end
      end
      default:
        next_s.st = adcc_pkg::CONV_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '{st: adcc_pkg::CONV_IDLE, cnt: '0, last: '0, done: 1'b0};
    else
      s <= next_s;
  end

  assign conv.done = s.done;
  assign conv.busy = (s.st == adcc_pkg::CONV_RUN);
endmodule : adcc_conv_seq
`default_nettype wire

/* File: logic/adcc_pkg.sv */
// adcc_pkg: register map, field positions, reset values and timing counts of the converter control unit.
// assumes a 32-bit classic wishbone slave with byte addresses and one register per aligned word.
package adcc_pkg;
  // byte offsets of the registers
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_RESULT   = 8'h04;
  localparam logic [7:0] OFS_CTRL_B   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  // bit positions of converter_control_status
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_START    = 6;
  localparam int BIT_AUTO     = 5;
  localparam int BIT_DONE     = 4;
  localparam int BIT_IRQ_EN   = 3;
  localparam int DIV_LSB      = 0;
  localparam int DIV_W        = 3;
  localparam int TRIG_W       = 3;
  // trigger source code that means free running
  localparam logic [TRIG_W-1:0] TRIG_FREE_RUN = 3'h0;
  // event bits of the interrupt status and mask registers
  localparam int EV_DONE      = 0;
  localparam int EV_ABORT     = 1;
  localparam int EV_TRIG_MISS = 2;
  localparam int EV_W         = 3;
  // conversion lengths in converter clock cycles
  localparam int FIRST_CONV_CYCLES  = 25;
  localparam int NORMAL_CONV_CYCLES = 13;
  localparam int CNT_W              = 5;
  // divider: widest division is 128, so a 7-bit counter
  localparam int PRE_W = 7;
  // reset values
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [31:0] DATA_ZERO    = 32'h0000_0000;
  // conversion sequencer states
  typedef enum logic { CONV_IDLE, CONV_RUN } adcc_conv_state_t;
endpackage : adcc_pkg

/* File: logic/adcc_prescaler.sv */
// adcc_prescaler: turns the system clock into a converter clock enable pulse.
// assumes div_sel is steady while run is high; a change only shifts the next tick.
`timescale 1ns/1ps
`default_nettype none
module adcc_prescaler (
  input  wire logic clk_i,
  input  wire logic rst_i,
  adcc_conv_if.divider conv
);
  typedef struct packed {
    logic [adcc_pkg::PRE_W-1:0] cnt;
    logic                       tick;
  } adcc_pre_state_t;

  adcc_pre_state_t s;
  adcc_pre_state_t next_s;

  // codes 0 and 1 both divide by two, the rest by two to the code
  function automatic logic [adcc_pkg::PRE_W-1:0] div_mask(input logic [adcc_pkg::DIV_W-1:0] sel);
    logic [adcc_pkg::PRE_W:0] full;
    full = '0;
    if (sel < 3'h2)
      full = 8'h01;
    else
      full = 8'((8'h01 << sel) - 8'h01);
    return full[adcc_pkg::PRE_W-1:0];
  endfunction : div_mask

  // count while powered; a tick on every wrap of the masked count
  always_comb
  begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (!conv.run)
      next_s.cnt = '0;
    else
    begin
      next_s.cnt = s.cnt + 7'h01;
      if ((s.cnt & div_mask(conv.div_sel)) == div_mask(conv.div_sel))
        next_s.tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign conv.tick = s.tick;
endmodule : adcc_prescaler
`default_nettype wire

/* File: logic/adcc_top.sv */
// adcc_top: control and status logic of the on-chip converter behind a classic wishbone slave.
// assumes a 10-bit analog core that presents its result when told a conversion began.
// What this block does
// - enable powers the converter; clearing it aborts a running conversion
// - start write begins each single conversion; free running needs it only once
// - first conversion after enabling takes 25 converter cycles, later ones 13
// - start bit reads one while converting; writing zero to it does nothing
// - auto trigger starts a conversion on each rising edge of the chosen trigger while idle; an edge while busy is a missed trigger
// - done flag sets when conversion ends and the result is updated
// - taking the interrupt vector clears the done flag in hardware
// - writing one clears the done flag; writing zero leaves it
// - done interrupt requested when flag, its enable and global enable are set
// - divider codes 0,1 divide by 2; codes 2..7 by 4 up to 128
`timescale 1ns/1ps
`default_nettype none
module adcc_top #(
  parameter int RESULT_W = 10,
  parameter int TRIG_N   = 8
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [RESULT_W-1:0] core_result_i,
  input  wire logic [TRIG_N-1:0]   trigger_i,
  input  wire logic                global_irq_enable_i,
  input  wire logic                vector_ack_i,
  output logic                     converter_power_o,
  output logic                     conv_sample_o,
  output logic                     conv_busy_o,
  output logic                     conv_done_irq_o,
  output logic                     irq_o
);
  typedef struct packed {
    logic                             enable;
    logic                             auto_trig;
    logic                             irq_en;
    logic [adcc_pkg::DIV_W-1:0]       div_sel;
    logic                             done_flag;
    logic                             busy;
    logic                             first_pending;
    logic [adcc_pkg::TRIG_W-1:0]      trig_sel;
    logic                             trig_prev;
    logic [adcc_pkg::EV_W-1:0]        irq_stat;
    logic [adcc_pkg::EV_W-1:0]        irq_mask;
    logic [15:0]                      result;
    logic                             ack;
    logic [31:0]                      rdata;
    logic                             sample;
    logic                             done_irq;
    logic                             irq;
  } adcc_state_t;

  adcc_state_t s;
  adcc_state_t next_s;

  adcc_conv_if conv ();

  adcc_prescaler u_prescaler (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .conv  (conv.divider)
  );

  adcc_conv_seq u_seq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .conv  (conv.seq)
  );

  // one decoder for every register select
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr == ofs;
  endfunction : reg_hit

  // bus decode: a request is answered one cycle after it appears
  logic       req;
  logic       wr;
  logic       wr_ctrl;
  logic       wr_ctrl_b;
  logic       wr_stat;
  logic       wr_mask;
  logic [7:0] wbyte;
  logic [7:0] ctrl_view;

  // writes take effect on the edge that the master samples ack
  assign req       = wb_cyc_i & wb_stb_i;
  assign wr        = req & wb_we_i & s.ack;
  assign wbyte     = wb_dat_i[7:0];
  assign wr_ctrl   = wr & wb_sel_i[0] & reg_hit(wb_adr_i, adcc_pkg::OFS_CTRL);
  assign wr_ctrl_b = wr & wb_sel_i[0] & reg_hit(wb_adr_i, adcc_pkg::OFS_CTRL_B);
  assign wr_stat   = wr & wb_sel_i[0] & reg_hit(wb_adr_i, adcc_pkg::OFS_IRQ_STAT);
  assign wr_mask   = wr & wb_sel_i[0] & reg_hit(wb_adr_i, adcc_pkg::OFS_IRQ_MASK);

  // control view; the start position mirrors the running conversion
  always_comb
  begin
    ctrl_view                                            = adcc_pkg::CTRL_RESET;
    ctrl_view[adcc_pkg::BIT_ENABLE]                      = s.enable;
    ctrl_view[adcc_pkg::BIT_START]                       = s.busy;
    ctrl_view[adcc_pkg::BIT_AUTO]                        = s.auto_trig;
    ctrl_view[adcc_pkg::BIT_DONE]                        = s.done_flag;
    ctrl_view[adcc_pkg::BIT_IRQ_EN]                      = s.irq_en;
    ctrl_view[adcc_pkg::DIV_LSB +: adcc_pkg::DIV_W]      = s.div_sel;
  end

  // control values as they stand after this cycle's write
  logic                        new_enable;
  logic                        new_auto;
  logic [adcc_pkg::TRIG_W-1:0] new_trig_sel;
  logic                        free_run;
  logic                        trig_now;
  logic                        trig_rise;
  logic                        sw_start;
  logic                        hw_start;
  logic                        auto_restart;
  logic                        start;
  logic                        abort;
  logic                        trig_miss;

  assign new_enable   = wr_ctrl ? wbyte[adcc_pkg::BIT_ENABLE] : s.enable;
  assign new_auto     = wr_ctrl ? wbyte[adcc_pkg::BIT_AUTO] : s.auto_trig;
  assign new_trig_sel = wr_ctrl_b ? wbyte[adcc_pkg::TRIG_W-1:0] : s.trig_sel;
  assign free_run     = new_auto & (new_trig_sel == adcc_pkg::TRIG_FREE_RUN);
  assign trig_now     = trigger_i[s.trig_sel];
  assign trig_rise    = trig_now & ~s.trig_prev;
  // a zero in the start position never starts or stops anything
  assign sw_start     = wr_ctrl & wbyte[adcc_pkg::BIT_START] & new_enable;
  assign hw_start     = new_auto & ~free_run & trig_rise & new_enable;
  assign auto_restart = conv.done & free_run & new_enable;
  // starts are only taken while idle; done frees the sequencer in the same cycle
  assign start        = (sw_start | hw_start | auto_restart) & (~s.busy | conv.done);
  assign abort        = s.busy & ~conv.done & ~new_enable;
  assign trig_miss    = new_auto & ~free_run & trig_rise & new_enable & s.busy & ~conv.done;

  // drive the shared interface
  assign conv.run     = s.enable;
  assign conv.div_sel = s.div_sel;
  assign conv.start   = start;
  // a start written together with the enable is owed the long conversion as well
  assign conv.first   = s.first_pending | (new_enable & ~s.enable);
  assign conv.abort   = abort;

  // next state: bus answer, control fields, flags and events
  always_comb
  begin
    logic [adcc_pkg::EV_W-1:0] ev;
    ev                  = '0;
    next_s              = s;
    next_s.sample       = 1'b0;
    next_s.trig_prev    = trig_now;
    // bus answer and registered read data
    next_s.ack          = req & ~s.ack;
    if (req & ~s.ack)
    begin
      if (reg_hit(wb_adr_i, adcc_pkg::OFS_CTRL))
        next_s.rdata = {24'h00_0000, ctrl_view};
      else if (reg_hit(wb_adr_i, adcc_pkg::OFS_RESULT))
        next_s.rdata = {16'h0000, s.result};
      else if (reg_hit(wb_adr_i, adcc_pkg::OFS_CTRL_B))
        next_s.rdata = {29'h0000_0000, s.trig_sel};
      else if (reg_hit(wb_adr_i, adcc_pkg::OFS_IRQ_STAT))
        next_s.rdata = {29'h0000_0000, s.irq_stat};
      else if (reg_hit(wb_adr_i, adcc_pkg::OFS_IRQ_MASK))
        next_s.rdata = {29'h0000_0000, s.irq_mask};
      else
        next_s.rdata = adcc_pkg::DATA_ZERO;
    end
    // control register write; the result pair has no write path
    if (wr_ctrl)
    begin
      next_s.enable    = wbyte[adcc_pkg::BIT_ENABLE];
      next_s.auto_trig = wbyte[adcc_pkg::BIT_AUTO];
      next_s.irq_en    = wbyte[adcc_pkg::BIT_IRQ_EN];
      next_s.div_sel   = wbyte[adcc_pkg::DIV_LSB +: adcc_pkg::DIV_W];
      if (wbyte[adcc_pkg::BIT_DONE])
        next_s.done_flag = 1'b0;
    end
    if (wr_ctrl_b)
      next_s.trig_sel = wbyte[adcc_pkg::TRIG_W-1:0];
    if (wr_mask)
      next_s.irq_mask = wbyte[adcc_pkg::EV_W-1:0];
    if (wr_stat)
      next_s.irq_stat = s.irq_stat & ~wbyte[adcc_pkg::EV_W-1:0];
    // vector fetch clears the flag, but a completion this cycle still sets it
    if (vector_ack_i)
      next_s.done_flag = 1'b0;
    // the long conversion is owed from every off-to-on change of enable
    if (new_enable & ~s.enable)
      next_s.first_pending = 1'b1;
    if (~new_enable)
      next_s.first_pending = 1'b0;
    // completion: result and flag in the same edge
    if (conv.done)
    begin
      next_s.result    = 16'(core_result_i);
      next_s.done_flag = 1'b1;
      next_s.busy      = 1'b0;
      ev[adcc_pkg::EV_DONE] = 1'b1;
    end
    if (abort)
    begin
      next_s.busy = 1'b0;
      ev[adcc_pkg::EV_ABORT] = 1'b1;
    end
    if (start)
    begin
      next_s.busy          = 1'b1;
      next_s.sample        = 1'b1;
      next_s.first_pending = 1'b0;
    end
    ev[adcc_pkg::EV_TRIG_MISS] = trig_miss;
    // events set after clears so that a set wins
    next_s.irq_stat = next_s.irq_stat | ev;
    next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);
    next_s.done_irq = next_s.done_flag & next_s.irq_en & global_irq_enable_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  // every output straight from the state register
  assign wb_dat_o          = s.rdata;
  assign wb_ack_o          = s.ack;
  assign converter_power_o = s.enable;
  assign conv_sample_o     = s.sample;
  assign conv_busy_o       = s.busy;
  assign conv_done_irq_o   = s.done_irq;
  assign irq_o             = s.irq;
endmodule : adcc_top
`default_nettype wire

/* File: verification/adcc_core_model.sv */
// adcc_core_model: analog core and trigger sources beside the converter control unit.
// assumes the bench asks for trigger pulses; the result moves only when a conversion begins.
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sample_i,
  input  wire logic       fire_i,
  input  wire logic [2:0] fire_sel_i,
  output logic      [9:0] result_o,
  output logic      [7:0] trigger_o
);
  // new value per sampled conversion, steady until the next one so a late read stays valid
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      result_o <= 10'h2C5;
    else if (sample_i)
      result_o <= result_o + 10'h03A;
    trigger_o <= 8'h00;
    trigger_o[fire_sel_i] <= fire_i;
  end
endmodule : adcc_core_model
`default_nettype wire

/* File: verification/adcc_top_asserts.sv */
// adcc_top_asserts: timing checks on the converter control unit, seen from its top ports only.
// assumes one clock and a synchronous active-high reset; bound to adcc_top below.
`timescale 1ns/1ps
`default_nettype none
module adcc_top_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic global_irq_enable_i,
  input wire logic converter_power_o,
  input wire logic conv_sample_o,
  input wire logic conv_busy_o,
  input wire logic conv_done_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        wr_ack;
  logic [11:0] busy_cnt;
  // a completed write is the only way software can touch the enable bit
  assign wr_ack = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  // busy cycles since the last start; the longest legal run is 25 ticks of 128
  always_ff @(posedge clk_i)
  begin
    if (rst_i || conv_sample_o || !conv_busy_o)
      busy_cnt <= 12'h000;
    else
      busy_cnt <= busy_cnt + 12'h001;
  end
  property p_ack_resp; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing after request");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_busy_power; conv_busy_o |-> converter_power_o; endproperty
  a_busy_power: assert property (p_busy_power) else $error("busy while powered down");
  property p_power_write; $rose(converter_power_o) |-> ($past(wr_ack) || $past(wr_ack, 2)); endproperty
  a_power_write: assert property (p_power_write) else $error("power rose without a write");
  property p_sample_busy; conv_sample_o |-> conv_busy_o && converter_power_o; endproperty
  a_sample_busy: assert property (p_sample_busy) else $error("sample pulse while idle");
  property p_min_len; conv_sample_o |=> (conv_busy_o || !converter_power_o) [*8]; endproperty
  a_min_len: assert property (p_min_len) else $error("conversion ended too soon");
  property p_max_len; busy_cnt < 12'hCE4; endproperty
  a_max_len: assert property (p_max_len) else $error("conversion ran too long");
  property p_irq_gie; conv_done_irq_o |-> $past(global_irq_enable_i); endproperty
  a_irq_gie: assert property (p_irq_gie) else $error("done interrupt without global enable");
endmodule : adcc_top_asserts
bind adcc_top adcc_top_asserts u_adcc_top_asserts (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .global_irq_enable_i(global_irq_enable_i),
  .converter_power_o(converter_power_o), .conv_sample_o(conv_sample_o), .conv_busy_o(conv_busy_o),
  .conv_done_irq_o(conv_done_irq_o));
`default_nettype wire

/* File: verification/adcc_top_test.sv */
// adcc_top_test: self-checking bench for the converter control unit.
// assumes the register map of adcc_pkg and a partner model for the analog side.
`timescale 1ns/1ps
`default_nettype none
module adcc_top_test;
  typedef struct packed { logic we; logic [7:0] a; logic [31:0] d; } adcc_row_t;
  logic clk_i, rst_i, cyc, stb, we, gie, vack, fire;
  logic [7:0]  adr;
  logic [2:0]  fsel;
  logic [31:0] dat, rd;
  logic [31:0] dat_o;
  logic ack, pwr, smp, busy, dirq, irq;
  logic [9:0] res;
  logic [7:0] trig;
  int bad_count, total_checks, samples, s0, n, d;
  // reads carry the expected value in d; unmapped 0x14 and 0x18 must read zero
  adcc_row_t rows [13] = '{'{1'h0, 8'h00, 32'h0}, '{1'h0, 8'h04, 32'h0}, '{1'h0, 8'h08, 32'h0},
    '{1'h0, 8'h0C, 32'h0}, '{1'h0, 8'h10, 32'h0}, '{1'h0, 8'h14, 32'h0}, '{1'h1, 8'h10, 32'h7},
    '{1'h0, 8'h10, 32'h7}, '{1'h1, 8'h08, 32'h3}, '{1'h0, 8'h08, 32'h3}, '{1'h1, 8'h18, 32'hFF},
    '{1'h0, 8'h18, 32'h0}, '{1'h1, 8'h08, 32'h0}};
  adcc_top u_adcc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .core_result_i(res), .trigger_i(trig), .global_irq_enable_i(gie), .vector_ack_i(vack),
    .converter_power_o(pwr), .conv_sample_o(smp), .conv_busy_o(busy), .conv_done_irq_o(dirq), .irq_o(irq));
  adcc_core_model u_adcc_core_model (.clk_i(clk_i), .rst_i(rst_i), .sample_i(smp), .fire_i(fire),
    .fire_sel_i(fsel), .result_o(res), .trigger_o(trig));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // counted at the edge, so the registered pulse is read before it updates
  always @(posedge clk_i)
    if (smp === 1'b1) samples++;
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic chk1(input logic g);
    total_checks++;
    if (g !== 1'b1)
    begin
      bad_count++;
      $display("MISMATCH %0t condition false", $time);
    end
  endtask : chk1
  // one classic cycle; ack is sampled at the rising edge, read data taken and the request dropped there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= v;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      bad_count++;
      close_out();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wait_busy(output int c);
    c = 0;
    @(negedge clk_i);
    while (busy === 1'b1 && c < 4000)
    begin
      c++;
      @(negedge clk_i);
    end
    if (c >= 4000)
    begin
      bad_count++;
      close_out();
    end
  endtask : wait_busy
  initial
  begin
    {cyc, stb, we, gie, vack, fire} = 6'h00;
    adr   = 8'h00;
    dat   = 32'h0000_0000;
    fsel  = 3'h0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i])
    begin
      bus(rows[i].we, rows[i].a, rows[i].d);
      if (!rows[i].we) chk(rd, rows[i].d);
    end
    $display("register table test done");
    // full values written, never read back and modified, so a set done flag is not lost
    bus(1'h1, 8'h00, 32'hC8);
    wait_busy(n);
    chk1(n >= 48 && n <= 52);
    bus(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h98);
    chk1(dirq === 1'b0);
    chk1(irq === 1'b1);
    gie <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk1(dirq === 1'b1);
    bus(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h2FF);
    bus(1'h1, 8'h04, 32'h1234);
    bus(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h2FF);
    bus(1'h1, 8'h00, 32'h88);
    bus(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h98);
    bus(1'h1, 8'h00, 32'h98);
    bus(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h88);
    chk1(dirq === 1'b0);
    $display("first conversion test done");
    bus(1'h1, 8'h00, 32'hC8);
    wait_busy(n);
    chk1(n >= 24 && n <= 28);
    @(posedge clk_i) vack <= 1'b1;
    @(posedge clk_i) vack <= 1'b0;
    bus(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h88);
    // the code goes in one write ahead: a tick of the old rate must not fall inside the timed conversion
    for (int c = 0; c < 8; c++)
    begin
      d = (c < 2) ? 2 : (1 << c);
      bus(1'h1, 8'h00, 32'h80 | c);
      bus(1'h1, 8'h00, 32'hC0 | c);
      wait_busy(n);
      chk1(n >= 12 * d && n <= 13 * d + 2);
    end
    $display("divider test done");
    bus(1'h1, 8'h00, 32'hD0);
    bus(1'h1, 8'h00, 32'h80);
    bus(1'h0, 8'h00, 32'h0);
    chk(rd, 32'hC0);
    bus(1'h1, 8'h0C, 32'h7);
    bus(1'h1, 8'h00, 32'h0);
    bus(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h2);
    chk1(busy === 1'b0 && pwr === 1'b0);
    bus(1'h1, 8'h00, 32'hC0);
    wait_busy(n);
    chk1(n >= 48 && n <= 52);
    $display("abort test done");
    bus(1'h1, 8'h00, 32'h80);
    samples = 0;
    bus(1'h1, 8'h00, 32'hE0);
    repeat (150) @(negedge clk_i);
    chk1(samples >= 4 && samples <= 6);
    bus(1'h1, 8'h00, 32'h0);
    $display("free running test done");
    bus(1'h1, 8'h08, 32'h3);
    bus(1'h1, 8'h00, 32'hA0);
    s0 = samples;
    for (int t = 2; t < 4; t++)
    begin
      @(posedge clk_i);
      fsel <= t[2:0];
      fire <= 1'b1;
      @(posedge clk_i) fire <= 1'b0;
      repeat (6) @(negedge clk_i);
      chk1(samples == s0 + t - 2);
    end
    // a second edge while the triggered conversion runs is refused and reported as missed
    bus(1'h1, 8'h0C, 32'h7);
    @(posedge clk_i);
    fire <= 1'b1;
    @(posedge clk_i) fire <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk1(samples == s0 + 1);
    bus(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h4);
    $display("trigger test done");
    // reset in mid conversion must bring power, busy, both interrupt outputs, the control and the result register back to zero
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk1(pwr === 1'b0 && busy === 1'b0 && irq === 1'b0 && dirq === 1'b0);
    bus(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    close_out();
  end
endmodule : adcc_top_test
`default_nettype wire
